// ==== acs_pkg.sv ====
package acs_pkg;

  // System and conversion clock rates
  localparam int SYS_CLK_HZ  = 100_000_000;
  localparam int CONV_CLK_HZ = 500_000;
  localparam int TICK_DIV    = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);
  localparam logic [7:0] EOC_CYCLES = 8'(TICK_DIV);

  // Conversion-clock cycles added to half the bit count
  localparam logic [3:0] CONV_EXTRA  = 4'h3;
  localparam logic [3:0] CYCLE_EXTRA = 4'h1;
  localparam logic [3:0] RES_BASE_HALF = 4'h3;

  localparam int SAMPLE_W = 13;
  localparam int FIFO_DEPTH = 16;
  localparam int RESULT_W = 16;

  // Serial command codes
  localparam logic [3:0] CMD_START      = 4'hc;
  localparam logic [6:0] CMD_READ_DATA  = 7'h20;
  localparam logic [7:0] CMD_WRITE_CFG  = 8'h44;
  localparam logic [7:0] CMD_READ_CFG   = 8'h46;

  // Status byte bit positions
  localparam int ST_PACKET = 7;
  localparam int ST_ADDR   = 6;
  localparam int ST_EOC    = 5;
  localparam int ST_OVF    = 4;

  // Byte 0 of the configuration holds the start bit here
  localparam int CFG_START_BIT = 0;

  typedef enum logic [1:0] {
    RES6  = 2'b00,
    RES8  = 2'b01,
    RES10 = 2'b10,
    RES12 = 2'b11
  } acs_res_type;

  // Bits [15:8] are configuration byte 0, [7:0] byte 1
  typedef struct packed {
    logic [3:0]  inputSelect;
    logic        powerOn;
    logic        differential;
    logic        refSelect;
    logic        startControl;
    logic        continuousRun;
    logic        justify;
    acs_res_type resolution;
    logic [3:0]  reserved;
  } acs_cfg_type;

  localparam logic [15:0] CFG_RESET = 16'h0020;

  typedef enum logic [1:0] {
    CONV_IDLE  = 2'b00,
    CONV_RUN   = 2'b01,
    CONV_STORE = 2'b10
  } acs_conv_type;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic csn;
  } acs_spi_type;

  typedef struct packed {
    logic       powerOn;
    logic       supplyMonitor;
    logic       externalRef;
    logic       differential;
    logic [1:0] channel;
    logic       converting;
  } acs_analog_type;

endpackage

// ==== acs_sync.sv ====
`timescale 1ns/100ps
module acs_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } acs_sync_state_type;

  acs_sync_state_type st;
  acs_sync_state_type next_st;

  always_comb begin
    next_st.first  = async;
    next_st.second = st.first;
  end

  // Reset clears both stages, so clock and select both read low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign synced = st.second;

endmodule

// ==== acs_fifo.sv ====
`timescale 1ns/100ps
module acs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wrPtr;
    logic [AW:0]                 rdPtr;
  } acs_fifo_state_type;

  acs_fifo_state_type st;
  acs_fifo_state_type next_st;
  logic               full;
  logic               empty;

  assign empty    = st.wrPtr == st.rdPtr;
  assign full     = (st.wrPtr[AW] != st.rdPtr[AW]) && (st.wrPtr[AW-1:0] == st.rdPtr[AW-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = st.mem[st.rdPtr[AW-1:0]];

  always_comb begin
    next_st = st;
    if (inValid && !full) begin
      next_st.mem[st.wrPtr[AW-1:0]] = inData;
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (outReady && !empty) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ==== acs_sequencer.sv ====
`timescale 1ns/100ps
// Behaviour
// - Resolution codes 00..11 give 6/8/10/12 bits
// - Resolution defaults to 10 bits
// - Differential uses input zero as inverting
// - Channel from select field or start command
// - Select MSB converts supply third, bandgap reference
// - Reference bit picks external pin or bandgap
// - Differential results offset by half scale
// - Justify bit places result top or bottom
// - Overflow flag updated after every conversion
// - Power bit cleared switches converter off
// - Start waits for select high, clock edge
// - Single mode converts once, pulses end
// - Start bit low or command aborts
// - Single conversion takes N/2 plus three
// - Continuous mode repeats every N/2 plus one
// - Sequencing runs on 500 kHz conversion clock
// - Status shows ready, match, end, overflow
// - Registers are readable back over serial
// - Start command is 1100 plus channel
// - Result read is 0100000 plus byte
// - Status byte shifts out first after select
module acs_sequencer (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire acs_pkg::acs_spi_type        spiPins,
  output logic                             miso,
  output logic                             misoOe_n,
  input  wire logic                        packetReady,
  input  wire logic                        addressHit,
  input  wire logic [acs_pkg::SAMPLE_W-1:0] sampleValue,
  output acs_pkg::acs_analog_type          analog,
  output logic                             endOfConversion,
  output logic [acs_pkg::RESULT_W-1:0]     resultWord,
  output logic                             resultValid,
  input  wire logic                        resultReady
);

  typedef struct packed {
    acs_pkg::acs_cfg_type  cfg;
    logic [15:0]           resultValue;
    logic                  overflowFlag;
    logic                  eocSticky;
    logic [7:0]            eocLeft;
    logic [7:0]            rxShift;
    logic [7:0]            txShift;
    logic [2:0]            bitCnt;
    logic [1:0]            byteCnt;
    logic [7:0]            cmd;
    logic                  sckPrev;
    logic                  csnPrev;
    logic                  startPending;
    logic [7:0]            tickCnt;
    acs_pkg::acs_conv_type conv;
    logic [3:0]            cycCnt;
  } acs_seq_state_type;

  acs_seq_state_type   st;
  acs_seq_state_type   n;
  acs_pkg::acs_spi_type spi;
  logic                sckRise;
  logic                sckFall;
  logic                csnFall;
  logic                tick;
  logic                storeNow;
  logic                pushReady;
  logic                cmdStart;
  logic [7:0]          rxByte;
  logic [7:0]          statusByte;
  logic [16:0]         fmt;
  logic [3:0]          tConv;
  logic [3:0]          tCycle;

  // Signed sample scaled to 12 bits, cut to N bits, offset, clamped
  function automatic logic [16:0] formatSample(
    input logic signed [acs_pkg::SAMPLE_W-1:0] raw,
    input acs_pkg::acs_res_type                res,
    input logic                                diff,
    input logic                                justify
  );
    int          bits;
    int          val;
    int          top;
    logic        ovf;
    logic [15:0] word;
    bits = 6 + 2 * int'(res);
    val  = int'(raw) >>> (12 - bits);
    if (diff) begin
      val = val + (1 << (bits - 1));
    end
    top = (1 << bits) - 1;
    ovf = (val < 0) || (val > top);
    if (val < 0) begin
      val = 0;
    end else if (val > top) begin
      val = top;
    end
    word = justify ? 16'(val) : 16'(val << (16 - bits));
    return {ovf, word};
  endfunction

  // Byte to present after `sent` bytes of a read command
  function automatic logic [7:0] txByteFor(
    input logic [7:0]           cmd,
    input logic [1:0]           sent,
    input acs_pkg::acs_cfg_type cfg,
    input logic [15:0]          data
  );
    logic [1:0] idx;
    logic [7:0] b;
    b = 8'h00;
    if (cmd[7:1] == acs_pkg::CMD_READ_DATA) begin
      idx = sent - 2'h1 + {1'b0, cmd[0]};
      if (idx == 2'h0) begin
        b = data[7:0];
      end else if (idx == 2'h1) begin
        b = data[15:8];
      end
    end else if (cmd == acs_pkg::CMD_READ_CFG) begin
      idx = sent - 2'h1;
      if (idx == 2'h0) begin
        b = cfg[15:8];
      end else if (idx == 2'h1) begin
        b = cfg[7:0];
      end
    end
    return b;
  endfunction

  // Pins come from port logic in another timing domain
  acs_sync #(
    .WIDTH (3)
  ) u_pinSync (
    .clk    (clk),
    .rst    (rst),
    .async  (spiPins),
    .synced (spi)
  );

  acs_fifo #(
    .WIDTH (acs_pkg::RESULT_W),
    .DEPTH (acs_pkg::FIFO_DEPTH)
  ) u_resultFifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (storeNow),
    .inReady  (pushReady),
    .inData   (fmt[15:0]),
    .outValid (resultValid),
    .outReady (resultReady),
    .outData  (resultWord)
  );

  assign sckRise = spi.sck && !st.sckPrev;
  assign sckFall = !spi.sck && st.sckPrev;
  assign csnFall = !spi.csn && st.csnPrev;
  assign tick    = st.tickCnt == acs_pkg::TICK_LAST;
  assign tConv   = {2'b00, st.cfg.resolution} + acs_pkg::RES_BASE_HALF + acs_pkg::CONV_EXTRA;
  assign tCycle  = {2'b00, st.cfg.resolution} + acs_pkg::RES_BASE_HALF + acs_pkg::CYCLE_EXTRA;
  assign fmt     = formatSample(sampleValue, st.cfg.resolution,
                                st.cfg.differential && !st.cfg.inputSelect[3], st.cfg.justify);
  assign rxByte  = {st.rxShift[6:0], spi.mosi};
  assign cmdStart = sckRise && !spi.csn && st.bitCnt == 3'h7 && st.byteCnt == 2'h0
                    && rxByte[7:4] == acs_pkg::CMD_START;

  always_comb begin
    statusByte = 8'h00;
    statusByte[acs_pkg::ST_PACKET] = packetReady;
    statusByte[acs_pkg::ST_ADDR]   = addressHit;
    statusByte[acs_pkg::ST_EOC]    = st.eocSticky;
    statusByte[acs_pkg::ST_OVF]    = st.overflowFlag;
  end

  always_comb begin
    n = st;
    storeNow  = 1'b0;
    n.sckPrev = spi.sck;
    n.csnPrev = spi.csn;
    n.tickCnt = tick ? 8'h00 : st.tickCnt + 8'h01;
    if (st.eocLeft != 8'h00) begin
      n.eocLeft = st.eocLeft - 8'h01;
    end

    case (st.conv)
      acs_pkg::CONV_IDLE: begin
        // begin on tick once select is high
        if (st.startPending && spi.csn && tick) begin
          n.conv         = acs_pkg::CONV_RUN;
          n.cycCnt       = tConv;
          n.startPending = 1'b0;
        end
      end
      acs_pkg::CONV_RUN: begin
        if (tick) begin
          if (st.cycCnt == 4'h1) begin
            // Full result buffer holds the conversion back
            if (pushReady) begin
              storeNow = 1'b1;
            end else begin
              n.conv = acs_pkg::CONV_STORE;
            end
          end else begin
            n.cycCnt = st.cycCnt - 4'h1;
          end
        end
      end
      acs_pkg::CONV_STORE: begin
        if (pushReady) begin
          storeNow = 1'b1;
        end
      end
      default: begin
        n.conv = acs_pkg::CONV_IDLE;
      end
    endcase

    // Chip select fall resets the frame; a store below still sets the flag
    if (csnFall) begin
      n.txShift   = statusByte;
      n.bitCnt    = 3'h0;
      n.byteCnt   = 2'h0;
      n.cmd       = 8'h00;
      n.eocSticky = 1'b0;
    end else if (sckFall && !spi.csn && st.bitCnt != 3'h0) begin
      n.txShift = {st.txShift[6:0], 1'b0};
    end

    if (storeNow) begin
      n.resultValue  = fmt[15:0];
      n.overflowFlag = fmt[16];
      n.eocSticky    = 1'b1;
      n.eocLeft      = acs_pkg::EOC_CYCLES;
      n.conv         = st.cfg.continuousRun ? acs_pkg::CONV_RUN : acs_pkg::CONV_IDLE;
      n.cycCnt       = tCycle;
    end

    if (sckRise && !spi.csn) begin
      n.rxShift = rxByte;
      n.bitCnt  = st.bitCnt + 3'h1;
      if (st.bitCnt == 3'h7) begin
        if (st.byteCnt == 2'h0) begin
          n.cmd = rxByte;
          if (rxByte[7:4] == acs_pkg::CMD_START) begin
            n.cfg.inputSelect = rxByte[3:0];
            n.conv         = acs_pkg::CONV_IDLE;
            n.startPending = 1'b1;
          end
        end else if (st.cmd == acs_pkg::CMD_WRITE_CFG) begin
          if (st.byteCnt == 2'h1) begin
            n.cfg[15:8] = rxByte;
            if (!st.cfg.startControl && rxByte[acs_pkg::CFG_START_BIT]) begin
              n.startPending = 1'b1;
            end
            if (st.cfg.startControl && !rxByte[acs_pkg::CFG_START_BIT]) begin
              n.conv         = acs_pkg::CONV_IDLE;
              n.startPending = 1'b0;
            end
          end else if (st.byteCnt == 2'h2) begin
            n.cfg[7:0] = {rxByte[7:4], 4'h0};
          end
        end
        if (st.byteCnt != 2'h3) begin
          n.byteCnt = st.byteCnt + 2'h1;
        end
        n.txShift = txByteFor(n.cmd, n.byteCnt, n.cfg, st.resultValue);
      end
    end

    if (!n.cfg.powerOn) begin
      n.conv         = acs_pkg::CONV_IDLE;
      n.startPending = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st         <= '0;
      st.cfg     <= acs_pkg::CFG_RESET;
      st.sckPrev <= 1'b0;
      st.csnPrev <= 1'b0;
    end else begin
      st <= n;
    end
  end

  assign miso            = spi.csn ? 1'b0 : st.txShift[7];
  assign misoOe_n        = spi.csn;
  assign endOfConversion = st.eocLeft != 8'h00;

  assign analog.powerOn       = st.cfg.powerOn;
  assign analog.supplyMonitor = st.cfg.inputSelect[3];
  assign analog.externalRef   = st.cfg.refSelect && !st.cfg.inputSelect[3];
  assign analog.differential  = st.cfg.differential && !st.cfg.inputSelect[3];
  assign analog.channel       = st.cfg.inputSelect[1:0];
  assign analog.converting    = st.conv != acs_pkg::CONV_IDLE;

  // Helper: conversion-clock ticks since run began or last store
  logic [3:0] runTicks;
  logic       firstRun;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      runTicks <= 4'h0;
      firstRun <= 1'b0;
    end else if (st.conv == acs_pkg::CONV_IDLE && n.conv == acs_pkg::CONV_RUN) begin
      runTicks <= 4'h0;
      firstRun <= 1'b1;
    end else if (storeNow) begin
      runTicks <= 4'h0;
      firstRun <= 1'b0;
    end else if (tick && st.conv == acs_pkg::CONV_RUN) begin
      runTicks <= runTicks + 4'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  res_default_a: assert property ($past(rst) |-> st.cfg.resolution == acs_pkg::RES10)
    else $error("resolution not 10 bits after reset");
  conv_time_a: assert property (storeNow && st.conv == acs_pkg::CONV_RUN |->
      runTicks + 4'h1 == (firstRun ? tConv : tCycle))
    else $error("conversion length wrong");
  eoc_width_a: assert property ($rose(endOfConversion) |-> endOfConversion [*8])
    else $error("end pulse too short");
  eoc_cause_a: assert property ($rose(endOfConversion) |-> $past(storeNow))
    else $error("end pulse without store");
  supply_ref_a: assert property (analog.supplyMonitor |-> !analog.externalRef)
    else $error("supply monitor uses external reference");
  left_fill_a: assert property (storeNow && !st.cfg.justify && st.cfg.resolution == acs_pkg::RES6
      |=> st.resultValue[9:0] == 10'h000)
    else $error("left justified low bits not zero");
  ovf_update_a: assert property (storeNow |=> st.overflowFlag == $past(fmt[16]))
    else $error("overflow flag not updated");
  abort_cmd_a: assert property (cmdStart |=>
      st.conv == acs_pkg::CONV_IDLE && st.startPending == st.cfg.powerOn)
    else $error("start command did not abort");
  power_off_a: assert property (!st.cfg.powerOn |-> st.conv == acs_pkg::CONV_IDLE)
    else $error("converter active while powered down");
  start_gate_a: assert property ($rose(st.conv == acs_pkg::CONV_RUN) && $past(st.conv)
      == acs_pkg::CONV_IDLE |-> $past(spi.csn) && $past(tick))
    else $error("conversion began before select high");
  status_first_a: assert property (csnFall |=> st.txShift == $past(statusByte))
    else $error("status not loaded first");

endmodule

// ==== acs_mcu_model.sv ====
`timescale 1ns/100ps
module acs_mcu_model (
  input  wire logic            clk,
  input  wire logic            miso,
  output acs_pkg::acs_spi_type spiPins
);
  initial begin
    spiPins = '{sck: 1'b0, mosi: 1'b0, csn: 1'b1};
  end

  task automatic frame(
    input  int          nBytes,
    input  logic [31:0] tx,
    output logic [31:0] rx
  );
    rx = 32'h0;
    @(posedge clk) spiPins.csn <= 1'b0;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 8 * nBytes; i++) begin
      spiPins.mosi <= tx[31 - i];
      repeat (10) @(posedge clk);
      // Mode 0: miso has settled long before the rising edge
      rx[31 - i] = miso;
      spiPins.sck <= 1'b1;
      repeat (10) @(posedge clk);
      spiPins.sck <= 1'b0;
    end
    repeat (10) @(posedge clk);
    spiPins.csn <= 1'b1;
    // Idle data line never shows the last bit again
    spiPins.mosi <= ~tx[32 - 8 * nBytes];
    @(posedge clk);
  endtask
endmodule

// ==== adc_conversion_sequencer_bench.sv ====
`timescale 1ns/100ps
module adc_conversion_sequencer_bench;
  typedef struct packed {
    logic [1:0]  res;
    logic        just;
    logic        diff;
    logic        refSel;
    logic [3:0]  inSel;
    logic [12:0] sample;
    logic [15:0] word;
    logic        ovf;
  } acs_row_type;

  localparam acs_row_type ROWS [5] = '{
    '{2'b10, 1'b0, 1'b0, 1'b1, 4'h1, 13'h0400, 16'h4000, 1'b0},
    '{2'b00, 1'b1, 1'b1, 1'b0, 4'h2, 13'h1f00, 16'h001c, 1'b0},
    '{2'b01, 1'b0, 1'b0, 1'b0, 4'h3, 13'h1000, 16'h0000, 1'b1},
    '{2'b11, 1'b1, 1'b0, 1'b1, 4'h8, 13'h0fff, 16'h0fff, 1'b0},
    '{2'b11, 1'b0, 1'b1, 1'b0, 4'h1, 13'h0800, 16'hfff0, 1'b1}
  };

  logic                    clk;
  logic                    rst;
  acs_pkg::acs_spi_type    spiPins;
  logic                    miso;
  logic                    misoOe_n;
  logic                    packetReady;
  logic                    addressHit;
  logic [12:0]             sampleValue;
  acs_pkg::acs_analog_type analog;
  logic                    endOfConversion;
  logic [15:0]             resultWord;
  logic                    resultValid;
  logic                    resultReady;
  int                      nErrors;
  int                      samplesChecked;
  int                      cyc;
  int                      t0;
  int                      t1;
  int                      t2;
  int                      lo;
  int                      n;
  logic                    seen;
  logic [31:0]             rx;
  logic [7:0]              b0;
  logic [7:0]              b1;
  acs_row_type             r;

  acs_sequencer dut_u (
    .clk             (clk),
    .rst             (rst),
    .spiPins         (spiPins),
    .miso            (miso),
    .misoOe_n        (misoOe_n),
    .packetReady     (packetReady),
    .addressHit      (addressHit),
    .sampleValue     (sampleValue),
    .analog          (analog),
    .endOfConversion (endOfConversion),
    .resultWord      (resultWord),
    .resultValid     (resultValid),
    .resultReady     (resultReady)
  );

  acs_mcu_model mcu_u (
    .clk     (clk),
    .miso    (miso),
    .spiPins (spiPins)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] want);
    samplesChecked++;
    if (got !== want) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, want, got);
    end
  endtask

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Rise time of the pulse, then its width in system cycles
  task automatic waitEoc(input int limit, output logic got, output int tRise);
    int k;
    got = 1'b0;
    tRise = 0;
    k = 0;
    while (!got && k < limit) begin
      @(negedge clk);
      k++;
      if (endOfConversion === 1'b1) begin
        got = 1'b1;
        tRise = cyc;
      end
    end
    if (got) begin
      k = 1;
      @(negedge clk);
      while (endOfConversion === 1'b1 && k < 400) begin
        k++;
        @(negedge clk);
      end
      check("eoc width", 16'(k), 16'(acs_pkg::EOC_CYCLES));
    end
  endtask

  task automatic resetCheck();
    logic [31:0] rd;
    @(posedge clk) rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(negedge clk);
    check("eoc after reset", endOfConversion, 16'h0);
    check("valid after reset", resultValid, 16'h0);
    check("power after reset", analog.powerOn, 16'h0);
    check("oe idle", misoOe_n, 16'h1);
    mcu_u.frame(3, {8'h46, 24'h0}, rd);
    check("status", rd[31:24], {packetReady, addressHit, 6'h0});
    check("config reset", {rd[23:16], rd[15:8]}, acs_pkg::CFG_RESET);
  endtask

  initial begin
    rst = 1'b1;
    cyc = 0;
    nErrors = 0;
    samplesChecked = 0;
    packetReady = 1'b1;
    addressHit = 1'b0;
    sampleValue = 13'h0000;
    resultReady = 1'b0;
    resetCheck();
    packetReady <= 1'b0;
    addressHit <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      r = ROWS[i];
      b0 = {4'h0, 1'b1, r.diff, r.refSel, 1'b0};
      b1 = {1'b0, r.just, r.res, 4'h0};
      sampleValue <= r.sample;
      mcu_u.frame(3, {8'h44, b0, b1, 8'h00}, rx);
      mcu_u.frame(3, {8'h46, 24'h0}, rx);
      check("config", {rx[23:16], rx[15:8]}, {b0, b1});
      mcu_u.frame(1, {4'hc, r.inSel, 24'h0}, rx);
      t0 = cyc;
      repeat (250) @(negedge clk);
      check("analog", 16'({1'b1, r.inSel[3], r.refSel & ~r.inSel[3],
        r.diff & ~r.inSel[3], r.inSel[1:0], 1'b1}), 16'(analog));
      lo = (3 + r.res + 3) * acs_pkg::TICK_DIV;
      waitEoc(3000, seen, t1);
      check("single eoc", seen, 16'h1);
      check("conv time", (t1 - t0 >= lo) && (t1 - t0 <= lo + 205), 16'h1);
      check("fifo valid", resultValid, 16'h1);
      check("fifo word", resultWord, r.word);
      @(posedge clk) resultReady <= 1'b1;
      @(posedge clk) resultReady <= 1'b0;
      mcu_u.frame(3, {8'h40, 24'h0}, rx);
      check("status ovf", rx[31:24], {3'b011, r.ovf, 4'h0});
      check("data reg", {rx[15:8], rx[23:16]}, r.word);
      check("fifo empty", resultValid, 16'h0);
    end

    // Continuous 6-bit run with the consumer stalled fills the buffer
    sampleValue <= 13'h0400;
    mcu_u.frame(3, {8'h44, 8'h09, 8'h80, 8'h00}, rx);
    waitEoc(2000, seen, t1);
    waitEoc(1000, seen, t2);
    check("cycle time", 16'(t2 - t1), 16'(4 * acs_pkg::TICK_DIV));
    for (int k = 2; k < 16; k++) waitEoc(1000, seen, t2);
    check("sixteen eoc", seen, 16'h1);
    waitEoc(1200, seen, t2);
    check("full stall", seen, 16'h0);
    check("full valid", resultValid, 16'h1);
    mcu_u.frame(3, {8'h44, 8'h08, 8'h80, 8'h00}, rx);
    n = 0;
    while (resultValid === 1'b1 && n < 40) begin
      check("drained word", resultWord, 16'h4000);
      @(posedge clk) resultReady <= 1'b1;
      @(posedge clk) resultReady <= 1'b0;
      @(negedge clk);
      n++;
    end
    check("drained count", 16'(n), 16'(acs_pkg::FIFO_DEPTH));
    waitEoc(1200, seen, t2);
    check("aborted", seen, 16'h0);

    @(posedge clk);
    mcu_u.frame(3, {8'h41, 24'h0}, rx);
    check("read from byte1", {rx[23:16], rx[15:8]}, 16'h4000);
    mcu_u.frame(2, {8'h20, 24'h0}, rx);
    check("unknown cmd", rx[23:16], 16'h0);

    // Power off refuses a start command
    mcu_u.frame(3, {8'h44, 8'h00, 8'h20, 8'h00}, rx);
    check("powered off", analog.powerOn, 16'h0);
    mcu_u.frame(1, {8'hc1, 24'h0}, rx);
    waitEoc(2000, seen, t2);
    check("off no eoc", seen, 16'h0);

    // Reset in the middle of a conversion
    mcu_u.frame(3, {8'h44, 8'h08, 8'h20, 8'h00}, rx);
    mcu_u.frame(1, {8'hc1, 24'h0}, rx);
    repeat (400) @(negedge clk);
    resetCheck();
    reportAndStop();
  end

  // Normal run is near 40k cycles; a hang stops at 90k, over twice that
  initial begin
    repeat (90000) @(posedge clk);
    nErrors++;
    reportAndStop();
  end
endmodule
